// ==== rtl/lsc_pkg.sv ====
// Constants, types and register map of the load shedding controller
// How it works
// [R01] With no AC on either line input, drop the self power hold.
// [R02] Split-phase service: no management, all relays on, meter blank, 50 A lit.
// [R03] Both lines plus generator sense: all relays on, show current, generator lit.
// [R04] Both lines, no generator sense: 30 A shore power, management enabled.
// [R05] Operator presses service select to choose the 20 A limit.
// [R06] Managed mode compares current with 30 A or 20 A and sheds above it.
// [R07] Entering managed mode starts with all relays closed.
// [R08] Over the limit, open the next relay of the shedding table.
// [R09] Each shed stores the current drop as that load's learned value.
// [R10] Keep shedding while above the limit, stop below it or at six.
// [R11] Restore last shed load when under limit and headroom covers its value.
// [R12] A shed load stays off at least two minutes.
// [R13] Six independent relay outputs; one to four line, five and six low voltage.
// [R14] Limit resets to 30 A; each button press toggles 30 A and 20 A.
// [R15] Current arrives as periodic unsigned ampere samples; decisions made per sample.
package lsc_pkg;

    // ------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------
    localparam int          LSC_LOADS      = 6;
    localparam int          LSC_AMP_W      = 8;
    localparam int          LSC_ADDR_W     = 4;
    localparam int          LSC_DATA_W     = 8;
    localparam longint      LSC_CLK_HZ     = 64'd25000000;
    localparam longint      LSC_HOLD_S     = 64'd120;
    localparam logic [31:0] LSC_HOLD_CYC   = 32'(LSC_HOLD_S * LSC_CLK_HZ);
    localparam logic [7:0]  LSC_LIMIT_30   = 8'h1E;
    localparam logic [7:0]  LSC_LIMIT_20   = 8'h14;
    localparam logic        LSC_LIM20_RST  = 1'b0;
    localparam logic [5:0]  LSC_ALL_ON     = 6'h3F;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [3:0]  LSC_ADDR_STAT  = 4'h0;
    localparam logic [3:0]  LSC_ADDR_CUR   = 4'h1;
    localparam logic [3:0]  LSC_ADDR_CTRL  = 4'h2;
    localparam logic [3:0]  LSC_ADDR_LRN0  = 4'h4;
    localparam int          LSC_CTRL_TGL   = 0;

    typedef enum logic [1:0] {
        LSC_OFF,
        LSC_FULL50,
        LSC_GEN,
        LSC_MANAGED
    } lsc_mode_e;

    typedef struct packed {
        logic       meter_blank;
        logic       ind_50a;
        logic       ind_gen;
        logic       ind_30a;
        logic [5:0] status_led;
        logic [7:0] meter_value;
    } lsc_disp_s;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } lsc_bus_s;

    function automatic logic [7:0] lsc_sat_sub(input logic [7:0] a, input logic [7:0] b);
        return (a > b) ? 8'(a - b) : 8'h00;
    endfunction

endpackage

// ==== rtl/lsc_hold_timer.sv ====
// Minimum off-time timer restarted on every shed
module lsc_hold_timer
    import lsc_pkg::*;
#(
    parameter logic [31:0] HOLD_CYCLES = LSC_HOLD_CYC
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic start,
    output logic      done
);

    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;

    assign cnt_next = start ? HOLD_CYCLES : ((cnt_reg != 32'h0) ? cnt_reg - 32'h1 : 32'h0);
    assign done     = (cnt_reg == 32'h0);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 32'h0;
        end else begin
            cnt_reg <= cnt_next; // [R12]
        end
    end

endmodule // lsc_hold_timer

// ==== rtl/lsc_ctrl.sv ====
// Load shedding controller top: source classification, shedding, learning, restore
//
// The implementer's own choices: the address map and the address-and-strobe port.
module lsc_ctrl
    import lsc_pkg::*;
#(
    parameter logic [31:0] HOLD_CYCLES = LSC_HOLD_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        line_a_sense,
    input  wire logic        line_b_sense,
    input  wire logic        split_phase_sense,
    input  wire logic        generator_sense_input,
    input  wire logic        service_select_btn,
    input  wire logic [7:0]  cur_sample,
    input  wire logic        cur_valid,
    input  wire lsc_bus_s    bus_in,
    output logic [7:0]       bus_rdata,
    output logic [5:0]       relay_on,
    output logic             power_hold,
    output lsc_disp_s        disp
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    lsc_mode_e   mode_reg;
    lsc_mode_e   mode_next;
    logic [5:0]  relay_reg;
    logic [5:0]  relay_next;
    logic [2:0]  shed_cnt_reg;
    logic [2:0]  shed_cnt_next;
    logic        pend_reg;
    logic        pend_next;
    logic [7:0]  before_reg;
    logic [7:0]  before_next;
    logic [7:0]  sample_reg;
    logic        lim20_reg;
    logic        btn_reg;
    logic [7:0]  rdata_reg;
    logic [7:0]  learned_reg [LSC_LOADS];

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire        both_lines   = line_a_sense & line_b_sense;
    wire        any_line     = line_a_sense | line_b_sense;
    wire        btn_rise     = service_select_btn & ~btn_reg;
    wire        sw_toggle    = bus_in.wr && (bus_in.addr == LSC_ADDR_CTRL)
                               && bus_in.wdata[LSC_CTRL_TGL];
    wire        toggle       = btn_rise | sw_toggle;
    wire [7:0]  limit        = lim20_reg ? LSC_LIMIT_20 : LSC_LIMIT_30;
    wire        managed      = (mode_reg == LSC_MANAGED);
    wire        over         = cur_sample > limit; // [R06]
    wire        under        = cur_sample < limit;
    wire [2:0]  last_idx     = 3'(shed_cnt_reg - 3'h1);
    wire [7:0]  headroom     = lsc_sat_sub(limit, cur_sample);
    wire [7:0]  drop         = lsc_sat_sub(before_reg, cur_sample);
    wire        hold_done;
    wire        can_shed     = managed && cur_valid && over
                               && (shed_cnt_reg < 3'(LSC_LOADS));
    wire        can_restore  = managed && cur_valid && !pend_reg && under
                               && (shed_cnt_reg != 3'h0) && hold_done
                               && (headroom >= learned_reg[last_idx]);
    wire        do_learn     = managed && cur_valid && pend_reg;
    wire        do_shed      = can_shed && !can_restore;
    wire        rd_learn     = (bus_in.addr >= LSC_ADDR_LRN0)
                               && (bus_in.addr < LSC_ADDR_LRN0 + 4'(LSC_LOADS));
    wire [2:0]  rd_idx       = 3'(bus_in.addr - LSC_ADDR_LRN0);

    // ------------------------------------------------------------
    // Source classification
    // ------------------------------------------------------------
    always_comb begin
        if (!any_line) begin
            mode_next = LSC_OFF; // [R01]
        end else if (both_lines && split_phase_sense) begin
            mode_next = LSC_FULL50; // [R02]
        end else if (both_lines && generator_sense_input) begin
            mode_next = LSC_GEN; // [R03]
        end else begin
            mode_next = LSC_MANAGED; // [R04]
        end
    end

    // ------------------------------------------------------------
    // Shedding, learning and restore
    // ------------------------------------------------------------
    always_comb begin
        relay_next    = relay_reg;
        shed_cnt_next = shed_cnt_reg;
        pend_next     = pend_reg;
        before_next   = before_reg;
        if (mode_next == LSC_OFF) begin
            // Unpowered controller cannot hold any relay closed
            relay_next    = 6'h00; // [R01]
            shed_cnt_next = 3'h0;
            pend_next     = 1'b0;
        end else if ((mode_next != LSC_MANAGED) || !managed) begin
            // Non-managed sources and entry to managed both start all closed
            relay_next    = LSC_ALL_ON; // [R02] [R03] [R07]
            shed_cnt_next = 3'h0;
            pend_next     = 1'b0;
        end else begin
            if (do_learn) begin
                pend_next = 1'b0;
            end
            if (do_shed) begin
                relay_next[shed_cnt_reg] = 1'b0; // [R08] [R10] [R13]
                shed_cnt_next            = 3'(shed_cnt_reg + 3'h1);
                pend_next                = 1'b1;
                before_next              = cur_sample;
            end else if (can_restore) begin
                relay_next[last_idx] = 1'b1; // [R11]
                shed_cnt_next        = last_idx;
            end
        end
    end

    lsc_hold_timer #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_hold (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .start   (do_shed),
        .done    (hold_done)
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg     <= LSC_OFF;
            relay_reg    <= 6'h00;
            shed_cnt_reg <= 3'h0;
            pend_reg     <= 1'b0;
            before_reg   <= 8'h00;
        end else begin
            mode_reg     <= mode_next;
            relay_reg    <= relay_next;
            shed_cnt_reg <= shed_cnt_next;
            pend_reg     <= pend_next;
            before_reg   <= before_next;
        end
    end

    // Learned value replaces the old one on the sample after each shed
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < LSC_LOADS; i++) begin
                learned_reg[i] <= 8'h00;
            end
        end else if (do_learn) begin
            learned_reg[last_idx] <= drop; // [R09]
        end
    end

    // ------------------------------------------------------------
    // Limit select and sample capture
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lim20_reg  <= LSC_LIM20_RST; // [R14]
            btn_reg    <= 1'b0;
            sample_reg <= 8'h00;
        end else begin
            btn_reg <= service_select_btn;
            if (toggle) begin
                lim20_reg <= ~lim20_reg; // [R05] [R14]
            end
            if (cur_valid) begin
                sample_reg <= cur_sample; // [R15]
            end
        end
    end

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    wire [7:0] rd_mux =
        (bus_in.addr == LSC_ADDR_STAT) ? {lim20_reg, 1'b0, relay_reg} :
        (bus_in.addr == LSC_ADDR_CUR)  ? sample_reg :
        (bus_in.addr == LSC_ADDR_CTRL) ? {3'h0, mode_reg, shed_cnt_reg} :
        rd_learn                       ? learned_reg[rd_idx] : 8'h00;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= bus_in.rd ? rd_mux : 8'h00;
        end
    end

    assign bus_rdata = rdata_reg;

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign relay_on          = relay_reg; // [R13]
    assign power_hold        = (mode_reg != LSC_OFF); // [R01]
    assign disp.meter_blank  = (mode_reg == LSC_FULL50); // [R02]
    assign disp.ind_50a      = (mode_reg == LSC_FULL50);
    assign disp.ind_gen      = (mode_reg == LSC_GEN); // [R03]
    assign disp.ind_30a      = managed && !lim20_reg;
    assign disp.status_led   = relay_reg;
    assign disp.meter_value  = sample_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_off_no_hold: assert property ( // [R01]
        !line_a_sense && !line_b_sense |=> !power_hold && disp.status_led == 6'h00)
        else $error("Power hold kept without line");

    chk_full50_out: assert property ( // [R02]
        both_lines && split_phase_sense |=> relay_on == 6'h3F && disp.meter_blank
            && disp.ind_50a && disp.status_led == 6'h3F)
        else $error("Full service outputs wrong");

    chk_gen_out: assert property ( // [R03]
        both_lines && !split_phase_sense && generator_sense_input
            |=> relay_on == 6'h3F && disp.ind_gen && !disp.meter_blank)
        else $error("Generator outputs wrong");

    chk_shore_managed: assert property ( // [R04]
        both_lines && !split_phase_sense && !generator_sense_input
            |=> mode_reg == LSC_MANAGED)
        else $error("Shore power not managed");

    chk_entry_all_on: assert property ( // [R07]
        $rose(mode_reg == LSC_MANAGED) |-> relay_on == 6'h3F && shed_cnt_reg == 3'h0)
        else $error("Managed entry not all on");

    chk_shed_step: assert property ( // [R08]
        managed && mode_next == LSC_MANAGED && cur_valid && cur_sample > limit
            && shed_cnt_reg < 3'h6
            |=> shed_cnt_reg == $past(shed_cnt_reg) + 3'h1
            && relay_on[$past(shed_cnt_reg)] == 1'b0)
        else $error("Over limit did not shed");

    chk_learn_value: assert property ( // [R09]
        managed && mode_next == LSC_MANAGED && cur_valid && pend_reg
            |=> learned_reg[$past(last_idx)] == lsc_sat_sub($past(before_reg), $past(cur_sample)))
        else $error("Learned value wrong");

    chk_shed_bound: assert property ( // [R10]
        mode_reg != LSC_OFF
            |-> shed_cnt_reg <= 3'h6 && $countones(~relay_on) == 32'(shed_cnt_reg))
        else $error("Shed count out of step");

    chk_restore_cond: assert property ( // [R11]
        managed && $fell(shed_cnt_reg != 3'h0) || (managed && shed_cnt_reg < $past(shed_cnt_reg)
            && $past(mode_reg) == LSC_MANAGED)
            |-> $past(cur_sample) < $past(limit) && $past(hold_done))
        else $error("Restore without headroom");

    chk_hold_time: assert property ( // [R12]
        do_shed |=> !hold_done [*8])
        else $error("Hold released early");

    chk_limit_toggle: assert property ( // [R14]
        btn_rise |=> lim20_reg != $past(lim20_reg))
        else $error("Button did not toggle limit");

    // Cycles since the latest shed, saturating; covers the whole off-time,
    // which a short repetition cannot reach
    logic [31:0] since_shed_reg;
    logic [31:0] since_shed_next;

    assign since_shed_next = do_shed ? 32'h0
                           : (since_shed_reg == 32'hFFFF_FFFF) ? since_shed_reg
                           : 32'(since_shed_reg + 32'h1);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            since_shed_reg <= 32'hFFFF_FFFF;
        end else begin
            since_shed_reg <= since_shed_next;
        end
    end

    chk_hold_count: assert property ( // [R12]
        managed && $past(mode_reg) == LSC_MANAGED && shed_cnt_reg < $past(shed_cnt_reg)
            |-> $past(since_shed_reg) >= HOLD_CYCLES)
        else $error("Load restored inside the hold time");

    chk_restore_step: assert property ( // [R11]
        can_restore && mode_next == LSC_MANAGED
            |=> relay_on[$past(last_idx)] && shed_cnt_reg == $past(last_idx))
        else $error("Restore did not reclose the last shed load");

    chk_equal_hold: assert property ( // [R06]
        managed && mode_next == LSC_MANAGED && cur_valid && cur_sample == limit
            |=> relay_on == $past(relay_on))
        else $error("Relays moved at the limit");

    chk_meter_sample: assert property ( // [R15]
        cur_valid |=> disp.meter_value == $past(cur_sample))
        else $error("Sample not shown on meter");

    cov_shed:    cover property (do_shed);
    cov_restore: cover property (can_restore && managed && mode_next == LSC_MANAGED);
    cov_gen:     cover property (mode_reg == LSC_GEN);
    cov_full50:  cover property (mode_reg == LSC_FULL50);
    cov_all_shed: cover property (managed && shed_cnt_reg == 3'h6);

endmodule // lsc_ctrl

// ==== verif/lsc_load_model.sv ====
// Far side model: relays feeding loads, and the neutral current sensor
module lsc_load_model
    import lsc_pkg::*;
#(
    parameter int PERIOD = 4
) (
    input  wire logic            clk_sys,
    input  wire logic            rst_n,
    input  wire logic [5:0]      relay_on,
    input  wire logic [5:0][7:0] load_amp,
    input  wire logic [7:0]      base_amp,
    output logic [7:0]           cur_sample,
    output logic                 cur_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    int         tick;
    logic [7:0] total;
    // A load draws current only while its relay is closed
    always_comb begin
        total = base_amp;
        for (int i = 0; i < LSC_LOADS; i++) begin
            if (relay_on[i]) total = 8'(total + load_amp[i]);
        end
    end
    // Stale sample is inverted each cycle, so it matches the last fresh one on alternate cycles
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tick <= 0;
            cur_valid <= 1'b0;
            cur_sample <= 8'h00;
        end else begin
            tick <= (tick == PERIOD - 1) ? 0 : tick + 1;
            cur_valid <= (tick == PERIOD - 1);
            cur_sample <= (tick == PERIOD - 1) ? total : ~cur_sample;
        end
    end
endmodule // lsc_load_model

// ==== verif/lsc_ctrl_tb.sv ====
// Self-checking bench of the load shedding controller
module lsc_ctrl_tb
    import lsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HOLD = 80;
    logic            clk_sys = 1'b0;
    logic            rst_n = 1'b0;
    logic            line_a_sense, line_b_sense, split_phase_sense, generator_sense_input;
    logic            service_select_btn;
    logic [7:0]      cur_sample, bus_rdata, base_amp, d;
    logic            cur_valid, power_hold, lim20;
    lsc_bus_s        bus_in;
    logic [5:0]      relay_on, relay_prev, mask;
    logic [5:0][7:0] load_amp;
    lsc_disp_s       disp;
    int              err_total, check_count, cyc, fall_cyc, n, lim, red;

    lsc_ctrl #(.HOLD_CYCLES(32'(HOLD))) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
        .line_a_sense(line_a_sense), .line_b_sense(line_b_sense),
        .split_phase_sense(split_phase_sense), .generator_sense_input(generator_sense_input),
        .service_select_btn(service_select_btn), .cur_sample(cur_sample),
        .cur_valid(cur_valid), .bus_in(bus_in), .bus_rdata(bus_rdata),
        .relay_on(relay_on), .power_hold(power_hold), .disp(disp));
    lsc_load_model #(.PERIOD(4)) loads (.clk_sys(clk_sys), .rst_n(rst_n),
        .relay_on(relay_on), .load_amp(load_amp), .base_amp(base_amp),
        .cur_sample(cur_sample), .cur_valid(cur_valid));

    always #20 clk_sys = ~clk_sys;

    // Timestamp of each shed, for the minimum off-time window
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        relay_prev <= relay_on;
        if (|(relay_prev & ~relay_on)) fall_cyc <= cyc;
        if (cyc == 5000) begin
            err_total++;
            results();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic results();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic bus_write(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        bus_in <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_in <= '0;
    endtask
    task automatic bus_read(input logic [3:0] a);
        @(posedge clk_sys);
        bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_in <= '0;
        @(negedge clk_sys);
        d = bus_rdata;
    endtask
    task automatic set_src(input logic [3:0] v);
        @(posedge clk_sys);
        {line_a_sense, line_b_sense, split_phase_sense, generator_sense_input} <= v;
        repeat (11) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    function automatic int cur_of(input logic [5:0] m);
        int s;
        s = base_amp;
        for (int k = 0; k < 6; k++) if (m[k]) s += load_amp[k];
        return s;
    endfunction
    function automatic int shed_n(input int l);
        int k;
        k = 0;
        while (k < 6 && cur_of(6'h3F << k) > l) k++;
        return k;
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {line_a_sense, line_b_sense, split_phase_sense, generator_sense_input} = 4'h0;
        {service_select_btn, lim20, bus_in, load_amp, base_amp} = '0;
        {err_total, check_count, cyc, fall_cyc} = '0;
        void'($urandom(86));
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int it = 0; it < 6; it++) begin
            case (it % 3)
                0: begin
                    set_src(4'h0);
                    check("power_hold", power_hold, 1'b0);
                    check("relays_off", relay_on, 6'h00);
                end
                1: begin
                    set_src(4'hE);
                    check("relays_50", relay_on, LSC_ALL_ON);
                    check("blank", {disp.meter_blank, disp.ind_50a}, 2'b11);
                    check("leds_50", disp.status_led, LSC_ALL_ON);
                end
                default: begin
                    set_src(4'hD);
                    check("relays_gen", relay_on, LSC_ALL_ON);
                    check("ind_gen", {disp.meter_blank, disp.ind_gen}, 2'b01);
                    check("meter", disp.meter_value, cur_of(6'h3F));
                    bus_read(LSC_ADDR_CTRL);
                    check("mode_gen", d[4:3], 2'd2);
                    bus_read(LSC_ADDR_CUR);
                    check("cur_reg", d, cur_of(6'h3F));
                end
            endcase
            if (it == 1 || it == 5) begin
                @(posedge clk_sys);
                service_select_btn <= 1'b1;
                repeat (3) @(posedge clk_sys);
                service_select_btn <= 1'b0;
                lim20 = ~lim20;
            end
            if (it == 3) begin
                bus_write(LSC_ADDR_CTRL, 8'h01);
                lim20 = ~lim20;
            end
            bus_write(4'hA, 8'h01);
            bus_read(LSC_ADDR_STAT);
            check("limit_sel", d[7], lim20);
            lim = lim20 ? LSC_LIMIT_20 : LSC_LIMIT_30;
            @(posedge clk_sys);
            for (int k = 0; k < 6; k++) load_amp[k] <= 8'(4 + $urandom % 7);
            base_amp <= 8'(10 + $urandom % 11);
            {line_a_sense, line_b_sense, split_phase_sense, generator_sense_input} <= 4'hC;
            @(posedge clk_sys);
            @(negedge clk_sys);
            check("relays_entry", relay_on, LSC_ALL_ON);
            check("power_on", power_hold, 1'b1);
            check("ind_30a", disp.ind_30a, !lim20);
            repeat (36) @(posedge clk_sys);
            n = shed_n(lim);
            mask = 6'h3F << n;
            @(negedge clk_sys);
            check("relays_shed", relay_on, mask);
            // Headroom lands exactly on the last shed load's learned value
            red = cur_of(mask) - lim + load_amp[n - 1];
            @(posedge clk_sys);
            base_amp <= 8'(base_amp - red);
            bus_read(LSC_ADDR_CTRL);
            check("mode_mgd", d[4:0], {2'd3, 3'(n)});
            for (int k = 0; k < n; k++) begin
                bus_read(LSC_ADDR_LRN0 + 4'(k));
                check("learned", d, load_amp[k]);
            end
            for (int w = 0; w < 200 && cyc < fall_cyc + HOLD - 3; w++) @(posedge clk_sys);
            @(negedge clk_sys);
            check("relays_held", relay_on, mask);
            for (int w = 0; w < 200 && cyc < fall_cyc + HOLD + 12; w++) @(posedge clk_sys);
            @(negedge clk_sys);
            check("relays_back", relay_on, mask | 6'(1 << (n - 1)));
        end
        results();
    end
endmodule // lsc_ctrl_tb
